// file: src/itimer_defs.svh
// constants for the interval timer, time base and clock output block
`ifndef ITIMER_DEFS_SVH
`define ITIMER_DEFS_SVH

`define ADDR_SUBCLK_OUT_SEL 16'hFF92
`define ADDR_TIMER_MODE 16'hFFB0
`define ADDR_TIMER_COUNT 16'hFFB1
`define ADDR_IRQ_STATUS 16'hFFB2
`define ADDR_IRQ_MASK 16'hFFB3
`define ADDR_MODULE_CLK_STOP 16'hFFFA

`define RST_TIMER_MODE 8'h10
`define RST_TIMER_COUNT 8'h00
`define RST_MODULE_CLK_STOP 8'hFF
`define RST_SUBCLK_OUT_SEL 8'hFE
`define TIMER_MODE_FIXED 8'h10
`define SUBCLK_OUT_FIXED 8'hFE

`define BIT_TOP_SELECT 3
`define BIT_CLEAR_SELECT 2
`define BIT_STANDBY_RELEASE 0
`define BIT_RAW_SUBCLK 0

`define SYS_PRESC_W 13
`define SUB_PRESC_W 15

`endif

// file: src/itimer_pkg.sv
// types shared by the timer block files
package itimer_pkg;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

    typedef enum logic [1:0] {
        PWR_ACTIVE = 2'b00,
        PWR_SLEEP = 2'b01,
        PWR_SUBACTIVE = 2'b10,
        PWR_OTHER = 2'b11
    } power_mode_e;

endpackage

// file: src/sync_pulse.sv
// two-stage synchronizer with rising-edge pulse for a subclock-derived level
`timescale 1ns/1ps
`default_nettype none
module sync_pulse
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // level in, pulse out
    input wire logic levelIn,
    output logic risePulse
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } st_s;

    st_s st_q;
    st_s st_d;

    always_comb
    begin
        st_d = st_q;
        st_d.s1 = levelIn;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    // only the second and third stage are looked at
    assign risePulse = st_q.s2 & ~st_q.s3;
endmodule
`default_nettype wire

// file: src/sub_divider.sv
// subclock-domain prescaler, clocked by the watch subclock
`timescale 1ns/1ps
`default_nettype none
module sub_divider
(
    // subclock and clear
    input wire logic subClk,
    input wire logic sys_rst,
    input wire logic holdClear,
    // divider taps
    output logic [14:0] taps
);
    typedef struct packed {
        logic [14:0] cnt;
    } st_s;

    st_s st_q;
    st_s st_d;

    always_comb
    begin
        st_d = st_q;
        st_d.cnt = st_q.cnt + 15'h0001;
    end

    // the clear is a register level that the caller does not synchronize; asynchronous
    // use is avoided so the prescaler clears cleanly on its own clock
    always_ff @(posedge subClk)
    begin
        if (sys_rst || holdClear)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign taps = st_q.cnt;
endmodule
`default_nettype wire

// file: src/interval_timebase_timer_clkout.sv
// interval timer, time base and divided clock output with register port
`timescale 1ns/1ps
`default_nettype none
`include "itimer_defs.svh"
module interval_timebase_timer_clkout
    import itimer_pkg::*;
(
    // system clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // watch subclock
    input wire logic subClk,
    // register port
    input wire logic [15:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    // chip state
    input wire power_mode_e powerMode,
    input wire logic timerOutEnable,
    // clock output pin
    output logic clockOutPin,
    output logic clockOutPinOe,
    // interrupt
    output logic irq
);
    typedef struct packed {
        logic [7:0] timerMode;
        logic [7:0] timerCount;
        logic [7:0] clkStop;
        logic rawSubclk;
        logic overflowFlag;
        logic overflowEnable;
        logic [12:0] sysPresc;
        logic [12:0] sysPrescPrev;
        logic [7:0] rdata;
        logic [4:0] subDivPrev;
        logic subSamp1;
        logic subSamp2;
        logic subSamp3;
        logic pinOut;
        logic pinOe;
    } st_s;

    st_s st_q;
    st_s st_d;
    reg_req_s req;
    logic [14:0] subTaps;
    logic subClear;
    logic subTickSel;
    logic subTick;
    logic sysTick;
    logic countTick;
    logic standby;
    logic overflow;

    function automatic logic [3:0] sys_tap(input logic [2:0] code);
        unique case (code)
            3'h0: sys_tap = 4'hC;
            3'h1: sys_tap = 4'hB;
            3'h2: sys_tap = 4'hA;
            3'h3: sys_tap = 4'h8;
            3'h4: sys_tap = 4'h7;
            3'h5: sys_tap = 4'h6;
            3'h6: sys_tap = 4'h4;
            3'h7: sys_tap = 4'h2;
        endcase
    endfunction

    function automatic logic [3:0] tb_tap(input logic [1:0] code);
        unique case (code)
            2'h0: tb_tap = 4'hE;
            2'h1: tb_tap = 4'hD;
            2'h2: tb_tap = 4'hC;
            2'h3: tb_tap = 4'h9;
        endcase
    endfunction

    assign req.addr = regAddr;
    assign req.wdata = regWdata;
    assign req.wr = regWr;
    assign req.rd = regRd;

    assign standby = ~st_q.clkStop[`BIT_STANDBY_RELEASE];
    // the clear level is taken from the register without a synchronizer;
    // it is quasi-static and only forces zero in the subclock domain
    assign subClear = standby
        | (st_q.timerMode[`BIT_TOP_SELECT]
        & st_q.timerMode[`BIT_CLEAR_SELECT]);

    sub_divider sub_divider_inst (
        .subClk(subClk),
        .sys_rst(sys_rst),
        .holdClear(subClear),
        .taps(subTaps)
    );

    // the time-base tap; prescaler wrap of the chosen width plus one bit is one period
    // of 256 counts, so the counter advances on tap bit (width - 8)
    assign subTickSel = subTaps[tb_tap(st_q.timerMode[1:0]) - 4'h8];

    sync_pulse sync_pulse_inst (
        .clk(clk),
        .sys_rst(sys_rst),
        .levelIn(subTickSel),
        .risePulse(subTick)
    );

    assign sysTick = st_q.sysPresc[sys_tap(st_q.timerMode[2:0])]
        & ~st_q.sysPrescPrev[sys_tap(st_q.timerMode[2:0])];

    // interval counting halts in subactive; time base keeps counting
    always_comb
    begin
        countTick = 1'b0;
        if (!standby)
        begin
            if (!st_q.timerMode[`BIT_TOP_SELECT])
                countTick = sysTick && (powerMode == PWR_ACTIVE
                    || powerMode == PWR_SLEEP);
            else if (!st_q.timerMode[`BIT_CLEAR_SELECT])
                countTick = subTick;
        end
    end

    assign overflow = countTick && (st_q.timerCount == 8'hFF);

    always_comb
    begin
        logic [2:0] sel;
        logic sysSel;
        logic subSel;
        sel = st_q.timerMode[7:5];
        sysSel = 1'b0;
        subSel = 1'b0;
        st_d = st_q;
        st_d.sysPresc = st_q.sysPresc + 13'h0001;
        st_d.sysPrescPrev = st_q.sysPresc;
        st_d.subSamp1 = subClk;
        st_d.subSamp2 = st_q.subSamp1;
        st_d.subSamp3 = st_q.subSamp2;
        st_d.rdata = 8'h00;

        // counter
        if (st_q.timerMode[`BIT_TOP_SELECT]
            && st_q.timerMode[`BIT_CLEAR_SELECT])
            st_d.timerCount = 8'h00;
        else if (countTick)
            st_d.timerCount = st_q.timerCount + 8'h01;

        // divided subclock for output, sampled in the system domain
        // the second and third stages feed a falling-edge detector
        if (st_q.subSamp3 && !st_q.subSamp2)
            st_d.subDivPrev = st_q.subDivPrev + 5'h01;

        // register writes
        if (req.wr)
        begin
            unique case (req.addr)
                `ADDR_TIMER_MODE:
                begin
                    st_d.timerMode = req.wdata | `TIMER_MODE_FIXED;
                    if (standby)
                        st_d.timerMode[`BIT_TOP_SELECT] =
                            st_q.timerMode[`BIT_TOP_SELECT];
                end
                `ADDR_MODULE_CLK_STOP: st_d.clkStop = req.wdata;
                `ADDR_SUBCLK_OUT_SEL:
                    st_d.rawSubclk = req.wdata[`BIT_RAW_SUBCLK];
                `ADDR_IRQ_STATUS:
                    if (req.wdata[0])
                        st_d.overflowFlag = 1'b0;
                `ADDR_IRQ_MASK: st_d.overflowEnable = req.wdata[0];
                default: ;
            endcase
        end
        // set beats a same-cycle clear
        if (overflow)
            st_d.overflowFlag = 1'b1;

        // register reads, data one cycle later
        if (req.rd)
        begin
            unique case (req.addr)
                `ADDR_TIMER_MODE: st_d.rdata = st_q.timerMode;
                `ADDR_TIMER_COUNT:
                    st_d.rdata = (powerMode == PWR_SUBACTIVE) ? 8'h00
                        : st_q.timerCount;
                `ADDR_MODULE_CLK_STOP: st_d.rdata = st_q.clkStop;
                `ADDR_SUBCLK_OUT_SEL:
                    st_d.rdata = `SUBCLK_OUT_FIXED
                        | {7'h00, st_q.rawSubclk};
                `ADDR_IRQ_STATUS: st_d.rdata = {7'h00, st_q.overflowFlag};
                `ADDR_IRQ_MASK: st_d.rdata = {7'h00, st_q.overflowEnable};
                default: st_d.rdata = 8'h00;
            endcase
        end

        // clock output selection
        sysSel = (powerMode == PWR_ACTIVE) || (powerMode == PWR_SLEEP);
        subSel = sysSel || (powerMode == PWR_SUBACTIVE);
        st_d.pinOe = timerOutEnable;
        st_d.pinOut = 1'b0;
        if (timerOutEnable)
        begin
            if (st_q.rawSubclk)
                st_d.pinOut = st_q.subSamp2;
            else if (!sel[2])
                st_d.pinOut = sysSel
                    & st_q.sysPresc[3'h4 - sel[1:0]];
            else
                st_d.pinOut = subSel
                    & st_q.subDivPrev[3'h4 - sel[1:0]];
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_q <= '0;
            st_q.timerMode <= `RST_TIMER_MODE;
            st_q.timerCount <= `RST_TIMER_COUNT;
            st_q.clkStop <= `RST_MODULE_CLK_STOP;
        end
        else
            st_q <= st_d;
    end

    assign regRdata = st_q.rdata;
    assign clockOutPin = st_q.pinOut;
    assign clockOutPinOe = st_q.pinOe;
    assign irq = st_q.overflowFlag & st_q.overflowEnable;

    // reset values reached
    reset_values_a: assert property (@(posedge clk)
        sys_rst |=> st_q.timerMode == 8'h10 && st_q.timerCount == 8'h00)
        else $error("reset values wrong");
    // bit 4 always set
    mode_bit4_a: assert property (@(posedge clk) disable iff (sys_rst)
        st_q.timerMode[4])
        else $error("mode bit 4 cleared");
    // counter held at zero in clear mode
    clear_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        st_q.timerMode[3] && st_q.timerMode[2] |=> st_q.timerCount == 8'h00)
        else $error("counter not held");
    // overflow sets flag
    overflow_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
        overflow |=> st_q.overflowFlag && st_q.timerCount == 8'h00)
        else $error("overflow flag not set");
    // counter steps by one
    count_step_a: assert property (@(posedge clk) disable iff (sys_rst)
        countTick && !overflow |=> st_q.timerCount == $past(st_q.timerCount) + 8'h01)
        else $error("counter step wrong");
    // irq gated by enable
    irq_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
        irq |-> st_q.overflowEnable && st_q.overflowFlag)
        else $error("irq without enable");
    // standby blocks top select change
    standby_lock_a: assert property (@(posedge clk) disable iff (sys_rst)
        standby |=> $stable(st_q.timerMode[3]))
        else $error("top select changed in standby");
    // pin only driven when enabled
    pin_enable_a: assert property (@(posedge clk) disable iff (sys_rst)
        !timerOutEnable |=> !clockOutPinOe && !clockOutPin)
        else $error("pin driven while disabled");
    // reserved bits of output select
    subsel_read_a: assert property (@(posedge clk) disable iff (sys_rst)
        regRd && regAddr == 16'hFF92 |=> regRdata[7:1] == 7'h7F)
        else $error("reserved bits not ones");
endmodule
`default_nettype wire

// file: verif/tb_interval_timebase_timer_clkout.sv
// self-checking bench for the interval timer block
`timescale 1ns/1ps
`default_nettype none
`include "itimer_defs.svh"
module tb_interval_timebase_timer_clkout
    import itimer_pkg::*;
;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic subClk = 1'b0;
    logic [15:0] regAddr = 16'h0000;
    logic [7:0] regWdata = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [7:0] regRdata;
    power_mode_e powerMode = PWR_ACTIVE;
    logic timerOutEnable = 1'b0;
    logic clockOutPin;
    logic clockOutPinOe;
    logic irq;
    int miscompares = 0;
    int cmp_count = 0;
    logic [7:0] a;
    logic [7:0] b;
    int n;

    always #2 clk = ~clk;
    // subclock kept ten times slower so pin sampling stays clean
    always #20 subClk = ~subClk;

    interval_timebase_timer_clkout interval_timebase_timer_clkout_inst (
        .clk(clk), .sys_rst(sys_rst), .subClk(subClk),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .powerMode(powerMode),
        .timerOutEnable(timerOutEnable), .clockOutPin(clockOutPin),
        .clockOutPinOe(clockOutPinOe), .irq(irq)
    );

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask

    task automatic wr(input logic [15:0] ad, input logic [7:0] d);
        @(posedge clk);
        regAddr <= ad;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] ad, output logic [7:0] d);
        @(posedge clk);
        regAddr <= ad;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask

    task automatic t_reset_and_fixed();
        rd(`ADDR_TIMER_MODE, a); chk(a, 8'h10);
        @(posedge clk);
        #1 chk(regRdata, 8'h00);
        rd(`ADDR_TIMER_COUNT, a); chk(a, 8'h00);
        rd(`ADDR_MODULE_CLK_STOP, a); chk(a, 8'hFF);
        rd(`ADDR_SUBCLK_OUT_SEL, a); chk(a, 8'hFE);
        rd(16'hFF00, a); chk(a, 8'h00);
        wr(`ADDR_TIMER_MODE, 8'h0C);
        rd(`ADDR_TIMER_MODE, a); chk(a, 8'h1C);
        wr(`ADDR_SUBCLK_OUT_SEL, 8'h00);
        rd(`ADDR_SUBCLK_OUT_SEL, a); chk(a, 8'hFE);
        wr(`ADDR_TIMER_COUNT, 8'h55);
        rd(`ADDR_TIMER_COUNT, a); chk(a, 8'h00);
    endtask

    task automatic t_dividers();
        int div [8] = '{8192, 4096, 2048, 512, 256, 128, 32, 8};
        for (int i = 0; i < 8; i++)
        begin
            wr(`ADDR_TIMER_MODE, 8'h0C);
            wr(`ADDR_TIMER_MODE, 8'(i));
            repeat (div[i] * 3) @(posedge clk);
            rd(`ADDR_TIMER_COUNT, a);
            repeat (div[i] - 2) @(posedge clk);
            rd(`ADDR_TIMER_COUNT, b);
            chk(b - a, 8'h01);
        end
    endtask

    task automatic t_overflow_irq();
        wr(`ADDR_TIMER_MODE, 8'h0C);
        wr(`ADDR_TIMER_MODE, 8'h07);
        repeat (248 * 8) @(posedge clk);
        rd(`ADDR_IRQ_STATUS, a); chk(a[0], 1'b0);
        repeat (10 * 8) @(posedge clk);
        rd(`ADDR_IRQ_STATUS, a); chk(a[0], 1'b1);
        rd(`ADDR_TIMER_COUNT, a); chk(8'(a < 8'h10), 8'h01);
        chk(irq, 1'b0);
        wr(`ADDR_IRQ_MASK, 8'h01);
        #1 chk(irq, 1'b1);
        wr(`ADDR_IRQ_STATUS, 8'h01);
        #1 chk(irq, 1'b0);
        wr(`ADDR_IRQ_MASK, 8'h00);
    endtask

    task automatic t_standby();
        wr(`ADDR_MODULE_CLK_STOP, 8'hFE);
        wr(`ADDR_TIMER_MODE, 8'h0F);
        rd(`ADDR_TIMER_MODE, a); chk(a, 8'h17);
        wr(`ADDR_MODULE_CLK_STOP, 8'hFF);
        wr(`ADDR_TIMER_MODE, 8'h0F);
        rd(`ADDR_TIMER_MODE, a); chk(a, 8'h1F);
    endtask

    task automatic t_timebase();
        // one tick each 4 subclocks, i.e. 40 system clocks
        wr(`ADDR_TIMER_MODE, 8'h0B);
        repeat (200) @(posedge clk);
        rd(`ADDR_TIMER_COUNT, a);
        repeat (398) @(posedge clk);
        rd(`ADDR_TIMER_COUNT, b);
        chk(8'((b - a) >= 9 && (b - a) <= 11), 8'h01);
        wr(`ADDR_TIMER_MODE, 8'h0C);
        repeat (200) @(posedge clk);
        rd(`ADDR_TIMER_COUNT, a); chk(a, 8'h00);
    endtask

    task automatic pin_highs(input int cyc, output int h);
        h = 0;
        repeat (cyc)
        begin
            @(posedge clk);
            #1 h += int'(clockOutPin);
        end
    endtask

    task automatic t_clock_out();
        wr(`ADDR_TIMER_MODE, 8'h6C);
        pin_highs(16, n); chk(8'(n), 8'h00);
        timerOutEnable <= 1'b1;
        repeat (3) @(posedge clk);
        chk(clockOutPinOe, 1'b1);
        pin_highs(16, n); chk(8'(n), 8'h08);
        wr(`ADDR_TIMER_MODE, 8'h0C);
        pin_highs(64, n); chk(8'(n), 8'h20);
        wr(`ADDR_TIMER_MODE, 8'hEC);
        pin_highs(400, n); chk(8'(n >= 180 && n <= 220), 8'h01);
        wr(`ADDR_SUBCLK_OUT_SEL, 8'h01);
        rd(`ADDR_SUBCLK_OUT_SEL, a); chk(a, 8'hFF);
        pin_highs(200, n); chk(8'(n >= 90 && n <= 110), 8'h01);
        wr(`ADDR_SUBCLK_OUT_SEL, 8'h00);
        powerMode <= PWR_SUBACTIVE;
        wr(`ADDR_TIMER_MODE, 8'h6C);
        pin_highs(32, n); chk(8'(n), 8'h00);
        wr(`ADDR_TIMER_MODE, 8'hEC);
        pin_highs(400, n); chk(8'(n >= 180 && n <= 220), 8'h01);
        wr(`ADDR_TIMER_MODE, 8'h0B);
        repeat (400) @(posedge clk);
        rd(`ADDR_TIMER_COUNT, a); chk(a, 8'h00);
        powerMode <= PWR_ACTIVE;
        timerOutEnable <= 1'b0;
        repeat (3) @(posedge clk);
        chk(clockOutPinOe, 1'b0);
    endtask

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset_and_fixed();
        t_dividers();
        t_overflow_irq();
        t_standby();
        t_timebase();
        t_clock_out();
        print_verdict();
    end

    // whole run needs about 66k clocks; stop at 90k
    initial
    begin
        #360000;
        miscompares++;
        print_verdict();
    end
endmodule
`default_nettype wire
